// >>> logic/tx_ovh_pkg.sv
// Package for the T1/E1 transmit overhead insertion block.
// Assumes one 250 MHz clock and an AXI4-Lite host with 32-bit data.
package tx_ovh_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int OFF_W = 9;
  localparam logic [OFF_W-1:0] IDX_ZCS1 = 9'h108;
  localparam logic [OFF_W-1:0] IDX_ZCS2 = 9'h109;
  localparam logic [OFF_W-1:0] IDX_ZCS3 = 9'h10a;
  localparam logic [OFF_W-1:0] IDX_FDL = 9'h162;
  localparam logic [OFF_W-1:0] IDX_BOC = 9'h163;
  localparam logic [OFF_W-1:0] IDX_W164 = 9'h164;
  localparam logic [OFF_W-1:0] IDX_W165 = 9'h165;
  localparam logic [OFF_W-1:0] IDX_W166 = 9'h166;
  localparam logic [OFF_W-1:0] IDX_SI_ODD = 9'h167;
  localparam logic [OFF_W-1:0] IDX_RA = 9'h168;
  localparam logic [OFF_W-1:0] IDX_SA4 = 9'h169;
  localparam logic [OFF_W-1:0] IDX_SA5 = 9'h16a;
  localparam logic [OFF_W-1:0] IDX_CTRL = 9'h1f0;
  localparam logic [OFF_W-1:0] IDX_STAT = 9'h1f1;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_E1 = 0;
  localparam int CTRL_ZCS_EN = 1;
  localparam int CTRL_D4 = 2;
  localparam int CTRL_PASS = 3;
  localparam int NA_FIXED = 6;
  localparam int BOC_W = 6;
  localparam int D4_FDL_W = 6;
  localparam int T1_CHANNELS = 24;
  localparam logic [7:0] RST_ALIGN = 8'h1b;
  localparam logic [7:0] RST_NONALIGN = 8'h40;
  localparam logic [3:0] LAST_FRAME = 4'hf;
  localparam logic [2:0] FDL_LAST_ESF = 3'h7;
  localparam logic [2:0] FDL_LAST_D4 = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ctrl;
    logic [23:0] zcs_sel;
    logic [7:0] fdl;
    logic [5:0] boc;
    logic [7:0] slc1;
    logic [7:0] slc2;
    logic [7:0] slc3;
    logic [7:0] align;
    logic [7:0] nonalign;
    logic [7:0] si_even;
    logic [7:0] si_odd;
    logic [7:0] ra;
    logic [7:0] sa4;
    logic [7:0] sa5;
  } regs_t;

  typedef struct packed {
    logic frame_start;
    logic chan_valid;
    logic [4:0] chan_idx;
    logic [7:0] chan_byte;
    logic [7:0] serial_ts0;
  } tx_in_t;

  typedef struct packed {
    logic [7:0] ts0;
    logic [7:0] data;
    logic fdl_bit;
    logic [5:0] boc;
    logic [5:0] fs;
  } tx_out_t;

endpackage

// >>> logic/t1_e1_tx_overhead_insert.sv
// Transmit overhead register set and insertion path for up to 8 ports.
// Assumes the framer gives a one-cycle frame_start per frame and
// presents each channel byte with its channel index.
`timescale 1ns/1ps
module t1_e1_tx_overhead_insert #(
  parameter int NPORTS = 8,
  parameter logic [7:0] ZERO_CODE = 8'h98
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite write address and data
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [tx_ovh_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // AXI4-Lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // AXI4-Lite read
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [tx_ovh_pkg::ADDR_W-1:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // Transmit path, one entry per port
  input wire tx_ovh_pkg::tx_in_t tx_in [NPORTS],
  output tx_ovh_pkg::tx_out_t tx_out [NPORTS]
);

  if (NPORTS < 1 || NPORTS > 8) begin : g_nports_check
    $error("NPORTS must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic known(logic [tx_ovh_pkg::OFF_W-1:0] off);
    case (off)
      tx_ovh_pkg::IDX_ZCS1, tx_ovh_pkg::IDX_ZCS2, tx_ovh_pkg::IDX_ZCS3,
      tx_ovh_pkg::IDX_FDL, tx_ovh_pkg::IDX_BOC, tx_ovh_pkg::IDX_W164,
      tx_ovh_pkg::IDX_W165, tx_ovh_pkg::IDX_W166, tx_ovh_pkg::IDX_SI_ODD,
      tx_ovh_pkg::IDX_RA, tx_ovh_pkg::IDX_SA4, tx_ovh_pkg::IDX_SA5,
      tx_ovh_pkg::IDX_CTRL, tx_ovh_pkg::IDX_STAT: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] rd_reg(tx_ovh_pkg::regs_t r,
      logic [7:0] st, logic [tx_ovh_pkg::OFF_W-1:0] off);
    logic e1;
    e1 = r.ctrl[tx_ovh_pkg::CTRL_E1];
    case (off)
      tx_ovh_pkg::IDX_ZCS1: rd_reg = r.zcs_sel[7:0];
      tx_ovh_pkg::IDX_ZCS2: rd_reg = r.zcs_sel[15:8];
      tx_ovh_pkg::IDX_ZCS3: rd_reg = r.zcs_sel[23:16];
      tx_ovh_pkg::IDX_FDL: rd_reg = r.fdl;
      tx_ovh_pkg::IDX_BOC: rd_reg = {2'h0, r.boc};
      tx_ovh_pkg::IDX_W164: rd_reg = e1 ? r.align : r.slc1;
      tx_ovh_pkg::IDX_W165: rd_reg = e1 ? r.nonalign : r.slc2;
      tx_ovh_pkg::IDX_W166: rd_reg = e1 ? r.si_even : r.slc3;
      tx_ovh_pkg::IDX_SI_ODD: rd_reg = r.si_odd;
      tx_ovh_pkg::IDX_RA: rd_reg = r.ra;
      tx_ovh_pkg::IDX_SA4: rd_reg = r.sa4;
      tx_ovh_pkg::IDX_SA5: rd_reg = r.sa5;
      tx_ovh_pkg::IDX_CTRL: rd_reg = {4'h0, r.ctrl};
      tx_ovh_pkg::IDX_STAT: rd_reg = st;
      default: rd_reg = 8'h00;
    endcase
  endfunction

  function automatic tx_ovh_pkg::regs_t wr_reg(tx_ovh_pkg::regs_t r,
      logic [tx_ovh_pkg::OFF_W-1:0] off, logic [7:0] v);
    logic e1;
    e1 = r.ctrl[tx_ovh_pkg::CTRL_E1];
    wr_reg = r;
    case (off)
      tx_ovh_pkg::IDX_ZCS1: wr_reg.zcs_sel[7:0] = v;
      tx_ovh_pkg::IDX_ZCS2: wr_reg.zcs_sel[15:8] = v;
      tx_ovh_pkg::IDX_ZCS3: wr_reg.zcs_sel[23:16] = v;
      tx_ovh_pkg::IDX_FDL: wr_reg.fdl = v;
      tx_ovh_pkg::IDX_BOC: wr_reg.boc = v[5:0];
      tx_ovh_pkg::IDX_W164: begin
        if (e1) wr_reg.align = v;
        else wr_reg.slc1 = v;
      end
      tx_ovh_pkg::IDX_W165: begin
        if (e1) wr_reg.nonalign = v | tx_ovh_pkg::RST_NONALIGN;
        else wr_reg.slc2 = v;
      end
      tx_ovh_pkg::IDX_W166: begin
        if (e1) wr_reg.si_even = v;
        else wr_reg.slc3 = v;
      end
      tx_ovh_pkg::IDX_SI_ODD: wr_reg.si_odd = v;
      tx_ovh_pkg::IDX_RA: wr_reg.ra = v;
      tx_ovh_pkg::IDX_SA4: wr_reg.sa4 = v;
      tx_ovh_pkg::IDX_SA5: wr_reg.sa5 = v;
      tx_ovh_pkg::IDX_CTRL: wr_reg.ctrl = v[3:0];
      default: wr_reg = r;
    endcase
  endfunction

  localparam tx_ovh_pkg::regs_t REGS_RST = '{
    align: tx_ovh_pkg::RST_ALIGN,
    nonalign: tx_ovh_pkg::RST_NONALIGN,
    default: '0
  };

  // ----------------------------------------------------------------
  // Register file and AXI4-Lite slave
  // ----------------------------------------------------------------
  tx_ovh_pkg::regs_t regs_q [NPORTS];
  tx_ovh_pkg::regs_t regs_d [NPORTS];
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [tx_ovh_pkg::IDX_W-1:0] aw_idx_q, aw_idx_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] status [NPORTS];
  logic [tx_ovh_pkg::IDX_W-1:0] ar_idx;
  logic [2:0] ar_port, aw_port;
  logic [tx_ovh_pkg::OFF_W-1:0] ar_off, aw_off;
  logic ar_hit, aw_hit;

  // Port number sits above the 9-bit offset: 0x200 stride per port
  assign ar_idx = araddr_in[tx_ovh_pkg::ADDR_W-1:2];
  assign ar_port = ar_idx[tx_ovh_pkg::IDX_W-1:tx_ovh_pkg::OFF_W];
  assign ar_off = ar_idx[tx_ovh_pkg::OFF_W-1:0];
  assign ar_hit = (32'(ar_port) < NPORTS) && known(ar_off);
  assign aw_port = aw_idx_q[tx_ovh_pkg::IDX_W-1:tx_ovh_pkg::OFF_W];
  assign aw_off = aw_idx_q[tx_ovh_pkg::OFF_W-1:0];
  assign aw_hit = (32'(aw_port) < NPORTS) && known(aw_off);

  always_comb begin
    regs_d = regs_q;
    aw_held_d = aw_held_q;
    aw_idx_d = aw_idx_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q && !bready_in;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready_in;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid_in && !aw_held_q) begin
      aw_held_d = 1'b1;
      aw_idx_d = awaddr_in[tx_ovh_pkg::ADDR_W-1:2];
    end
    if (wvalid_in && !w_held_q) begin
      w_held_d = 1'b1;
      w_data_d = wdata_in[7:0];
      w_lane_d = wstrb_in[0];
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = aw_hit ? tx_ovh_pkg::RESP_OKAY : tx_ovh_pkg::RESP_SLVERR;
      if (aw_hit && w_lane_q) begin
        regs_d[aw_port] = wr_reg(regs_q[aw_port], aw_off, w_data_q);
      end
    end
    if (arvalid_in && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = ar_hit ? tx_ovh_pkg::RESP_OKAY : tx_ovh_pkg::RESP_SLVERR;
      rdata_d = ar_hit ?
        {24'h0, rd_reg(regs_q[ar_port], status[ar_port], ar_off)} : '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regs_q <= '{default: REGS_RST};
      aw_held_q <= 1'b0;
      aw_idx_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= tx_ovh_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= tx_ovh_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else begin
      regs_q <= regs_d;
      aw_held_q <= aw_held_d;
      aw_idx_q <= aw_idx_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Ready flags are the negated hold flags (arready the negated rvalid), so they are flop outputs
  assign awready_out = !aw_held_q;
  assign wready_out = !w_held_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = !rvalid_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;

  // ----------------------------------------------------------------
  // Transmit overhead engine
  // ----------------------------------------------------------------
  // Shadow copies change only at the multiframe wrap, so a host write
  // landing mid-multiframe mixes no old and new overhead bits except the link byte, reloaded from the live register at each byte wrap.
  tx_ovh_pkg::regs_t shadow_q [NPORTS];
  tx_ovh_pkg::regs_t shadow_d [NPORTS];
  logic [3:0] frame_q [NPORTS];
  logic [3:0] frame_d [NPORTS];
  logic [2:0] fdl_idx_q [NPORTS];
  logic [2:0] fdl_idx_d [NPORTS];
  logic [7:0] fdl_sh_q [NPORTS];
  logic [7:0] fdl_sh_d [NPORTS];
  tx_ovh_pkg::tx_out_t tx_q [NPORTS];
  tx_ovh_pkg::tx_out_t tx_d [NPORTS];

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      logic [2:0] half;
      logic [2:0] fdl_last;
      logic zsub;
      tx_ovh_pkg::regs_t s;
      half = frame_q[p][3:1];
      s = shadow_q[p];
      fdl_last = s.ctrl[tx_ovh_pkg::CTRL_D4] ?
        tx_ovh_pkg::FDL_LAST_D4 : tx_ovh_pkg::FDL_LAST_ESF;
      zsub = !s.ctrl[tx_ovh_pkg::CTRL_E1] &&
        s.ctrl[tx_ovh_pkg::CTRL_ZCS_EN] &&
        (32'(tx_in[p].chan_idx) < tx_ovh_pkg::T1_CHANNELS) &&
        s.zcs_sel[tx_in[p].chan_idx] &&
        (tx_in[p].chan_byte == 8'h00);
      shadow_d[p] = shadow_q[p];
      frame_d[p] = frame_q[p];
      fdl_idx_d[p] = fdl_idx_q[p];
      fdl_sh_d[p] = fdl_sh_q[p];
      status[p] = {1'b0, fdl_idx_q[p], frame_q[p]};
      if (tx_in[p].frame_start) begin
        frame_d[p] = frame_q[p] + 4'h1;
        if (frame_q[p] == tx_ovh_pkg::LAST_FRAME) begin
          shadow_d[p] = regs_q[p];
        end
        if (fdl_idx_q[p] == fdl_last) begin
          fdl_idx_d[p] = 3'h0;
          fdl_sh_d[p] = regs_q[p].fdl;
        end else begin
          fdl_idx_d[p] = fdl_idx_q[p] + 3'h1;
          fdl_sh_d[p] = {1'b0, fdl_sh_q[p][7:1]};
        end
        // A switch into D4 at the wrap must not leave the index past the
        // sixth bit, or the byte would run on for two extra frames
        if (shadow_d[p].ctrl[tx_ovh_pkg::CTRL_D4] &&
            fdl_idx_d[p] > tx_ovh_pkg::FDL_LAST_D4) begin
          fdl_idx_d[p] = 3'h0;
          fdl_sh_d[p] = regs_q[p].fdl;
        end
      end
      tx_d[p].fdl_bit = fdl_sh_q[p][0];
      tx_d[p].fs = s.fdl[tx_ovh_pkg::D4_FDL_W-1:0];
      tx_d[p].boc = s.boc;
      // Time slot 0 word; meaningful only in E1 mode or with pass-through set
      if (s.ctrl[tx_ovh_pkg::CTRL_PASS]) begin
        tx_d[p].ts0 = tx_in[p].serial_ts0;
      end else if (!s.ctrl[tx_ovh_pkg::CTRL_E1]) begin
        tx_d[p].ts0 = 8'h00;
      end else if (!frame_q[p][0]) begin
        tx_d[p].ts0 = {s.si_even[half], s.align[6:0]};
      end else begin
        tx_d[p].ts0 = {s.si_odd[half], 1'b1, s.ra[half], s.sa4[half],
          s.sa5[half], s.nonalign[2:0]};
      end
      tx_d[p].data = tx_q[p].data;
      if (tx_in[p].chan_valid) begin
        tx_d[p].data = zsub ? ZERO_CODE : tx_in[p].chan_byte;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shadow_q <= '{default: REGS_RST};
      frame_q <= '{default: 4'h0};
      fdl_idx_q <= '{default: 3'h0};
      fdl_sh_q <= '{default: 8'h00};
      tx_q <= '{default: '0};
    end else begin
      shadow_q <= shadow_d;
      frame_q <= frame_d;
      fdl_idx_q <= fdl_idx_d;
      fdl_sh_q <= fdl_sh_d;
      tx_q <= tx_d;
    end
  end

  assign tx_out = tx_q;

  // ----------------------------------------------------------------
  // Assertions on port 0 and the host interface
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_zero_code_sub: assert property (
    tx_in[0].chan_valid && tx_in[0].chan_byte == 8'h00 &&
    tx_in[0].chan_idx < 5'd24 && !shadow_q[0].ctrl[0] &&
    shadow_q[0].ctrl[1] && shadow_q[0].zcs_sel[tx_in[0].chan_idx]
    |=> tx_out[0].data == ZERO_CODE)
    else $error("zero code not substituted");
  a_global_gate: assert property (
    tx_in[0].chan_valid && !shadow_q[0].ctrl[1]
    |=> tx_out[0].data == $past(tx_in[0].chan_byte))
    else $error("channel altered while stuffing disabled");
  a_fdl_lsb_first: assert property (
    tx_in[0].frame_start && fdl_idx_q[0] == 3'h7 && !shadow_q[0].ctrl[2]
    |=> ##1 tx_out[0].fdl_bit == $past(regs_q[0].fdl[0], 2))
    else $error("link byte not sent LSB first");
  a_d4_six_bits: assert property (
    shadow_q[0].ctrl[2] |-> fdl_idx_q[0] <= 3'h5 || $past(rst_in))
    else $error("D4 link counter beyond six bits");
  a_boc_upper_zero: assert property (
    rvalid_out && rresp_out == 2'h0 &&
    $past(araddr_in[10:2]) == 9'h163 |-> rdata_out[7:6] == 2'h0)
    else $error("message code upper bits not zero");
  a_align_frame: assert property (
    shadow_q[0].ctrl == 4'h1 && !frame_q[0][0]
    |=> tx_out[0].ts0[6:0] == $past(shadow_q[0].align[6:0]))
    else $error("align word pattern wrong");
  a_nonalign_one: assert property (
    shadow_q[0].ctrl == 4'h1 && frame_q[0][0] |=> tx_out[0].ts0[6])
    else $error("non-align fixed one missing");
  a_pass_through: assert property (
    shadow_q[0].ctrl[3] |=> tx_out[0].ts0 == $past(tx_in[0].serial_ts0))
    else $error("slot 0 not passed through");
  a_shadow_hold: assert property (
    !(tx_in[0].frame_start && frame_q[0] == 4'hf)
    |=> shadow_q[0] == $past(shadow_q[0]))
    else $error("shadow changed mid multiframe");
  a_write_resp: assert property (
    aw_held_q && w_held_q && !bvalid_q
    |=> bvalid_out && awready_out && wready_out)
    else $error("write response missing");

  c_e1_multiframe: cover property (
    tx_in[0].frame_start && frame_q[0] == 4'hf && shadow_q[0].ctrl[0]);
  c_zero_sub: cover property (tx_in[0].chan_valid && shadow_q[0].ctrl[1]
    ##1 tx_out[0].data == ZERO_CODE);
  c_bad_read: cover property (rvalid_out && rresp_out == 2'h2);

endmodule // t1_e1_tx_overhead_insert

// >>> tb/line_rx_model.sv
// Far end of the line for port 0: collects one link bit per frame.
// Assumes frame_in pulses once per frame in the transmit clock domain.
`timescale 1ns/1ps
module line_rx_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Line side of port 0
  input wire logic frame_in,
  input wire logic fdl_in
);
  // Receiver only listens; it never pushes back on the transmitter
  logic bits [$];

  always @(posedge clk_in) begin
    if (!rst_in && frame_in) begin
      bits.push_back(fdl_in);
    end
  end
endmodule // line_rx_model

// >>> tb/t1_e1_tx_overhead_insert_tb.sv
// Self-checking bench for the transmit overhead block, port 0 active.
// Assumes the package layout; ports 1 to 7 stay idle (inputs at zero).
`timescale 1ns/1ps
module t1_e1_tx_overhead_insert_tb;
  localparam logic [7:0] ZC = 8'h98;
  logic clk_in, rst_in, awvalid_in, awready_out, wvalid_in, wready_out;
  logic bvalid_out, bready_in, arvalid_in, arready_out, rvalid_out;
  logic rready_in;
  logic [13:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out;
  tx_ovh_pkg::tx_in_t tx_in [8];
  tx_ovh_pkg::tx_out_t tx_out [8];
  int fail_count, checked;

  t1_e1_tx_overhead_insert #(.NPORTS(8), .ZERO_CODE(ZC))
    t1_e1_tx_overhead_insert_i (.clk_in(clk_in), .rst_in(rst_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out),
    .awaddr_in(awaddr_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
    .wdata_in(wdata_in), .wstrb_in(wstrb_in), .bvalid_out(bvalid_out),
    .bready_in(bready_in), .bresp_out(bresp_out), .arvalid_in(arvalid_in),
    .arready_out(arready_out), .araddr_in(araddr_in),
    .rvalid_out(rvalid_out), .rready_in(rready_in), .rdata_out(rdata_out),
    .rresp_out(rresp_out), .tx_in(tx_in), .tx_out(tx_out));

  line_rx_model line_rx_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .frame_in(tx_in[0].frame_start), .fdl_in(tx_out[0].fdl_bit));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Write address and data go out together; bready stays up afterwards,
  // so a following call never re-raises it in the same time step
  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
      input logic [1:0] er = tx_ovh_pkg::RESP_OKAY);
    bit done;
    done = 0;
    awaddr_in <= {idx, 2'b00};
    wdata_in <= {24'h0, d};
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
      if (bvalid_out) begin
        done = 1;
        chk(bresp_out, er, "write response");
      end
    end
    chk(done, 1, "write answered");
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d,
      input logic [1:0] er = tx_ovh_pkg::RESP_OKAY);
    bit done;
    done = 0;
    araddr_in <= {idx, 2'b00};
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      if (rvalid_out) begin
        done = 1;
        d = rdata_out;
        chk(rresp_out, er, "read response");
      end
    end
    chk(done, 1, "read answered");
  endtask

  task automatic rc(input logic [11:0] idx, input logic [7:0] e,
      input logic [1:0] er = tx_ovh_pkg::RESP_OKAY);
    logic [31:0] d;
    rd(idx, d, er);
    chk(d, {24'h0, e}, "read data");
  endtask

  // Overhead other than the link byte reaches the line only at a multiframe wrap, so allow 17
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_in);
      tx_in[0].frame_start <= 1'b1;
      @(posedge clk_in);
      tx_in[0].frame_start <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask

  task automatic send_ch(input logic [4:0] ch, input logic [7:0] b, e);
    tx_in[0].chan_idx <= ch;
    tx_in[0].chan_byte <= b;
    tx_in[0].chan_valid <= 1'b1;
    @(posedge clk_in);
    tx_in[0].chan_valid <= 1'b0;
    @(posedge clk_in);
    chk(tx_out[0].data, e, "channel byte");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    logic [8:0] zi [6] = '{9'h162, 9'h163, 9'h167, 9'h168, 9'h169, 9'h16a};
    foreach (zi[i]) rc(zi[i], 8'h00);
    wr(tx_ovh_pkg::IDX_CTRL, 8'h01);
    rc(9'h164, 8'h1b);
    rc(9'h165, 8'h40);
    wr(9'h165, 8'h00);
    rc(9'h165, 8'h40);
    wr(9'h164, 8'h9b);
    wr(tx_ovh_pkg::IDX_CTRL, 8'h00);
    wr(9'h164, 8'ha5);
    rc(9'h164, 8'ha5);
    wr(tx_ovh_pkg::IDX_CTRL, 8'h01);
    rc(9'h164, 8'h9b);
    wr(9'h163, 8'hff);
    rc(9'h163, 8'h3f);
    wr({3'd7, 9'h162}, 8'h77);
    rc({3'd7, 9'h162}, 8'h77);
    rc(9'h162, 8'h00);
    // A write with lane 0 disabled is answered but stores nothing
    wstrb_in <= 4'h0;
    wr(9'h162, 8'h55);
    wstrb_in <= 4'h1;
    rc(9'h162, 8'h00);
    wr(9'h100, 8'h12, tx_ovh_pkg::RESP_SLVERR);
    rc(9'h100, 8'h00, tx_ovh_pkg::RESP_SLVERR);
  endtask

  task automatic sc_zero();
    wr(tx_ovh_pkg::IDX_CTRL, 8'h00);
    wr(tx_ovh_pkg::IDX_ZCS1, 8'h01);
    wr(tx_ovh_pkg::IDX_ZCS3, 8'h80);
    frames(17);
    send_ch(5'd0, 8'h00, 8'h00);
    wr(tx_ovh_pkg::IDX_CTRL, 8'h02);
    frames(17);
    send_ch(5'd0, 8'h00, ZC);
    send_ch(5'd1, 8'h00, 8'h00);
    send_ch(5'd23, 8'h00, ZC);
    send_ch(5'd0, 8'h01, 8'h01);
  endtask

  // Bit order is judged on a rotation, as the byte phase is free
  task automatic sc_link(input logic [7:0] ctl, fdl, input int p);
    bit ok, good;
    good = 0;
    wr(tx_ovh_pkg::IDX_CTRL, ctl);
    wr(tx_ovh_pkg::IDX_FDL, fdl);
    frames(20);
    chk(tx_out[0].fs, fdl[5:0], "fs pattern");
    chk(tx_out[0].boc, 6'h3f, "message code");
    line_rx_model_i.bits.delete();
    frames(2 * p);
    for (int k = 0; k < p; k++) begin
      ok = 1;
      for (int i = 0; i < 2 * p; i++) begin
        if (line_rx_model_i.bits[i] !== fdl[(i + k) % p]) ok = 0;
      end
      if (ok) good = 1;
    end
    chk(good, 1, "link bit order");
  endtask

  task automatic sc_e1();
    logic [8:0] wi [6] = '{9'h166, 9'h167, 9'h168, 9'h169, 9'h16a, 9'h165};
    logic [7:0] wv [6] = '{8'ha5, 8'h3c, 8'h96, 8'h0f, 8'hf0, 8'h45};
    logic [31:0] s;
    logic [7:0] e;
    int h;
    wr(tx_ovh_pkg::IDX_CTRL, 8'h01);
    foreach (wi[i]) wr(wi[i], wv[i]);
    frames(17);
    repeat (16) begin
      frames(1);
      rd(tx_ovh_pkg::IDX_STAT, s);
      h = int'(s[3:1]);
      e = s[0] ? {wv[1][h], 1'b1, wv[2][h], wv[3][h], wv[4][h], 3'b101}
               : {wv[0][h], 7'h1b};
      chk(tx_out[0].ts0, e, "slot 0 word");
    end
    wr(tx_ovh_pkg::IDX_CTRL, 8'h00);
    frames(17);
    chk(tx_out[0].ts0, 8'h00, "slot 0 in T1");
    tx_in[0].serial_ts0 <= 8'h5a;
    wr(tx_ovh_pkg::IDX_CTRL, 8'h09);
    frames(17);
    chk(tx_out[0].ts0, 8'h5a, "slot 0 pass-through");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    checked = 0;
    rst_in = 1'b1;
    {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = '0;
    awaddr_in = '0;
    araddr_in = '0;
    wdata_in = '0;
    wstrb_in = 4'h1;
    foreach (tx_in[i]) tx_in[i] = '0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    sc_regs();
    sc_zero();
    sc_link(8'h00, 8'h0b, 8);
    sc_link(8'h04, 8'h8b, 6);
    sc_e1();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    close_out();
  end
endmodule // t1_e1_tx_overhead_insert_tb
